// ==== tb_top.sv ====
// Self-checking bench for the timer channel
`timescale 1ns/10ps
`include "ttem_cfg.svh"
module tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, c0, c1;
  logic        pready, pslverr, prescale_tick, cmp_irq_ack, ovf_irq_ack;
  logic        pin_o, pin_oe, cmp_irq, ovf_irq, src_drv;
  wire logic   pin_w = pin_oe ? pin_o : src_drv;
  int          tgl_gap, tgl_cnt, num_errors, checks_done, cyc_n;
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc_n <= cyc_n + 1;
  ttem_timer #(.WIDTH(24)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescale_tick(prescale_tick), .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
    .timer_io_pin_i(pin_w), .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe), .cmp_irq(cmp_irq),
    .ovf_irq(ovf_irq));
  ttem_pin_src src (.pclk(pclk), .oe(pin_oe), .lvl(pin_w), .drv(src_drv), .gap(tgl_gap), .nt(tgl_cnt));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic e;
    rd(`TTEM_CSR_OFF, c0);
    chk("csr_reset", 32'h0, c0);
    wr(`TTEM_CMP_OFF, 32'hffffffff);
    rd(`TTEM_CMP_OFF, c0);
    chk("cmp_width", 32'h00ffffff, c0);
    wr(`TTEM_LOAD_OFF, 32'h00abcdef);
    rd(`TTEM_LOAD_OFF, c0);
    chk("load_read", 32'h0, c0);
    apb(1'b0, 12'h014, 32'h0, c0, e);
    chk("unmapped_err", 32'h1, e);
  endtask
  task automatic t_toggle();
    int n0;
    wr(`TTEM_LOAD_OFF, 32'h4);
    wr(`TTEM_CMP_OFF, 32'h9);
    wr(`TTEM_CSR_OFF, 32'h325);
    repeat (2) @(posedge pclk);
    chk("pin_oe", 32'h1, pin_oe);
    chk("pin_init", 32'h1, pin_o);
    n0 = tgl_cnt;
    for (int i = 0; i < 100 && tgl_cnt < n0 + 3; i++) @(posedge pclk);
    chk("toggle_gap", 32'd6, tgl_gap);
    chk("toggle_flag", 32'h1, cmp_irq);
    wr(`TTEM_CSR_OFF, 32'h324);
    chk("pin_oe_off", 32'h0, pin_oe);
    wr(`TTEM_LOAD_OFF, 32'hffffe0);
    wr(`TTEM_CMP_OFF, 32'hffffe8);
    wr(`TTEM_CSR_OFF, 32'h023);
    n0 = tgl_cnt;
    repeat (60) @(posedge pclk);
    chk("ovf_flag", 32'h1, ovf_irq);
    chk_rng("no_reload", 1, 1, tgl_cnt - n0);
    ovf_irq_ack <= 1'b1;
    @(posedge pclk);
    ovf_irq_ack <= 1'b0;
    @(posedge pclk);
    chk("ovf_clear", 32'h0, ovf_irq);
    wr(`TTEM_CSR_OFF, 32'h00300000);
  endtask
  task automatic t_event();
    wr(`TTEM_LOAD_OFF, 32'h0);
    wr(`TTEM_CMP_OFF, 32'h5);
    wr(`TTEM_CSR_OFF, 32'h235);
    repeat (2) begin
      src.send(1'b1, 4);
      src.send(1'b0, 4);
    end
    rd(`TTEM_CNT_OFF, c0);
    src.send(1'b1, 4);
    rd(`TTEM_CNT_OFF, c1);
    chk("count_rise", c0 + 1, c1);
    src.send(1'b0, 4);
    rd(`TTEM_CNT_OFF, c0);
    chk("count_fall", c1, c0);
    for (int i = 0; i < 8 && cmp_irq !== 1'b1; i++) begin
      src.send(1'b1, 4);
      src.send(1'b0, 4);
    end
    chk("event_match", 32'h1, cmp_irq);
    cmp_irq_ack <= 1'b1;
    @(posedge pclk);
    cmp_irq_ack <= 1'b0;
    @(posedge pclk);
    chk("ack_clear", 32'h0, cmp_irq);
    src.send(1'b1, 4);
    src.send(1'b0, 4);
    wr(`TTEM_CMP_OFF, 32'hffffff);
    wr(`TTEM_CSR_OFF, 32'h635);
    rd(`TTEM_CNT_OFF, c0);
    prescale_tick <= 1'b1;
    @(posedge pclk);
    prescale_tick <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(`TTEM_CNT_OFF, c1);
    chk("prescale_count", c0 + 1, c1);
    wr(`TTEM_CSR_OFF, 32'h0);
  endtask
  task automatic t_width();
    int t0;
    wr(`TTEM_LOAD_OFF, 32'h64);
    wr(`TTEM_CSR_OFF, 32'h245);
    for (int i = 0; i < 2; i++) begin
      t0 = cyc_n;
      src.send(1'b1, 20 + 10 * i);
      t0 = cyc_n - t0;
      src.send(1'b0, 10);
      rd(`TTEM_CAPT_OFF, c0);
      chk_rng("width", 99 + t0, 101 + t0, c0);
      chk("width_flag", 32'h1, cmp_irq);
      rd(`TTEM_CNT_OFF, c0);
      rd(`TTEM_CNT_OFF, c1);
      chk("width_halt", c0, c1);
      wr(`TTEM_CSR_OFF, 32'h00200245);
      chk("w1c_clear", 32'h0, cmp_irq);
    end
    wr(`TTEM_CSR_OFF, 32'h0);
  endtask
  task automatic t_period();
    int t0, t1;
    wr(`TTEM_LOAD_OFF, 32'h0);
    src.send(1'b1, 5);
    wr(`TTEM_CSR_OFF, 32'h355);
    t1 = cyc_n;
    src.send(1'b0, 15);
    src.send(1'b1, 15);
    for (int i = 0; i < 2; i++) begin
      t0 = t1;
      t1 = cyc_n;
      src.send(1'b0, 15);
      src.send(1'b1, 5);
      rd(`TTEM_CAPT_OFF, c0);
      chk_rng("period", t1 - t0 - 1, t1 - t0 + 1, c0);
      chk("period_flag", 32'h1, cmp_irq);
      wr(`TTEM_CSR_OFF, 32'h00200355);
    end
    wr(`TTEM_CSR_OFF, 32'h0);
  endtask
  task automatic t_capture();
    int t0;
    src.send(1'b0, 5);
    wr(`TTEM_CSR_OFF, 32'h065);
    t0 = cyc_n;
    repeat (40) @(posedge pclk);
    t0 = cyc_n - t0;
    src.send(1'b1, 10);
    rd(`TTEM_CAPT_OFF, c0);
    chk_rng("capture", t0 - 1, t0 + 5, c0);
    chk("capture_flag", 32'h1, cmp_irq);
    rd(`TTEM_CNT_OFF, c1);
    chk("capture_halt", c0, c1);
    cmp_irq_ack <= 1'b1;
    @(posedge pclk);
    cmp_irq_ack <= 1'b0;
    @(posedge pclk);
    chk("capture_ack", 32'h0, cmp_irq);
    wr(`TTEM_CSR_OFF, 32'h0);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, prescale_tick, cmp_irq_ack, ovf_irq_ack} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {num_errors, checks_done} = {32'd0, 32'd0};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_toggle();
    t_event();
    t_width();
    t_period();
    t_capture();
    tally_and_finish();
  end
endmodule

// ==== ttem_cfg.svh ====
// Register offsets, field positions, reset values and timing constants of the timer channel
`ifndef TTEM_CFG_SVH
`define TTEM_CFG_SVH

`define TTEM_CSR_OFF        12'h000
`define TTEM_LOAD_OFF       12'h004
`define TTEM_CMP_OFF        12'h008
`define TTEM_CAPT_OFF       12'h00c
`define TTEM_CNT_OFF        12'h010

`define TTEM_BIT_EN         0
`define TTEM_BIT_OVF_IE     1
`define TTEM_BIT_CMP_IE     2
`define TTEM_BIT_MODE_LO    4
`define TTEM_BIT_MODE_HI    7
`define TTEM_BIT_INV        8
`define TTEM_BIT_TRM        9
`define TTEM_BIT_PSC_SEL    10
`define TTEM_BIT_OVF_FLAG   20
`define TTEM_BIT_CMP_FLAG   21

`define TTEM_CSR_RESET      24'h000000
`define TTEM_CNT_RESET      24'h000000
`define TTEM_EXT_SYNC_STAGES 2

`endif

// ==== ttem_edge_if.sv ====
// Edge-detector hand-over between the timer core and its pin sampler
`timescale 1ns/10ps
interface ttem_edge_if;
  logic pin_level;
  logic rise;
  logic fall;
  modport sampler (output pin_level, output rise, output fall);
  modport core    (input  pin_level, input  rise, input  fall);
endinterface

// ==== ttem_pin_src.sv ====
// Behavioural source and load on the timer pin
`timescale 1ns/10ps
module ttem_pin_src (
  // Clock
  input  wire logic pclk,
  // Pin wire as seen by the load
  input  wire logic oe,
  input  wire logic lvl,
  // Source drive and toggle measurements
  output logic      drv,
  output int        gap,
  output int        nt
);
  int   age;
  logic prev;
  initial begin
    drv = 1'b0;
    gap = 0;
    nt = 0;
    age = 0;
    prev = 1'b0;
  end
  // Spacing of pin toggles while the device drives it
  always @(posedge pclk) begin
    age <= age + 1;
    if (oe && lvl !== prev) begin
      gap <= age + 1;
      nt <= nt + 1;
      age <= 0;
    end
    prev <= lvl;
  end
  // Each level is held at least three cycles, keeping the event rate under a quarter of pclk
  task automatic send(input logic v, input int n);
    @(posedge pclk);
    drv <= v;
    repeat ((n < 3) ? 3 : n) @(posedge pclk);
  endtask
endmodule

// ==== ttem_pin_sync.sv ====
// Pin synchroniser with edge detection on the settled level
`timescale 1ns/10ps
module ttem_pin_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw pin
  input  wire logic pin_in,
  // Synchronised result
  ttem_edge_if.sampler edge_out
);
  import ttem_pkg::*;

  if (STAGES < 2) begin : g_chk
    $error("ttem_pin_sync needs at least two stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] chain;
    logic              prev;
  } ttem_sync_s;

  ttem_sync_s st;
  ttem_sync_s next_st;

  always_comb begin
    next_st       = st;
    next_st.chain = {st.chain[STAGES-2:0], pin_in};
    next_st.prev  = st.chain[STAGES-1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_out.pin_level = st.chain[STAGES-1];
  assign edge_out.rise      = st.chain[STAGES-1] & ~st.prev;
  assign edge_out.fall      = ~st.chain[STAGES-1] & st.prev;
endmodule

// ==== ttem_pkg.sv ====
// Types shared by the timer channel files
package ttem_pkg;

  typedef enum logic [3:0] {
    TTEM_MODE_GPIO    = 4'h0,
    TTEM_MODE_PULSE   = 4'h1,
    TTEM_MODE_TOGGLE  = 4'h2,
    TTEM_MODE_EVENT   = 4'h3,
    TTEM_MODE_WIDTH   = 4'h4,
    TTEM_MODE_PERIOD  = 4'h5,
    TTEM_MODE_CAPTURE = 4'h6
  } ttem_mode_e;

  typedef enum logic [3:0] {
    TTEM_ST_IDLE  = 4'b0001,
    TTEM_ST_LOAD  = 4'b0010,
    TTEM_ST_WAIT  = 4'b0100,
    TTEM_ST_RUN   = 4'b1000
  } ttem_state_e;

  typedef logic [23:0] ttem_word_t;

endpackage

// ==== ttem_timer.sv ====
// Timer channel: toggle, event count, width, period and capture modes behind APB
//
// How it works
// - Mode 2 drives the pin as output, toggling from the internal clock.
// - On enable in toggle mode the pin output starts at the invert bit.
// - Toggle mode match inverts pin, sets compare flag, interrupt if enabled.
// - After match in modes 2/3, reload on next tick if reload set, else count on.
// - Software sets load to compare minus X plus one with reload set for toggles X cycles apart.
// - Modes 2 and 3 with reload set repeat count, compare, reload until enable clears.
// - Mode 3 takes the pin as input and counts events up to compare.
// - Mode 3 counts pin edges or prescaler ticks, chosen by a control bit.
// - The pin passes a synchroniser before it advances the counter.
// - Mode 3 counts falling edges with invert set, rising edges otherwise.
// - Measured counts may be off by one tick from synchronising the pin.
// - Mode 4 waits for a start edge, loads counter, counts clocks.
// - Width start edge is falling with invert set, rising otherwise.
// - Width end edge captures, sets compare flag, interrupts; stops counter if reload set.
// - Width mode with reload reloads on next start edge, else counts on.
// - Mode 5 measures between same-polarity edges chosen by invert bit.
// - Period first edge loads counter; next edge captures and flags.
// - Period mode restarts with reload set, else counts on and wraps at overflow.
// - Mode 6 counts from enable to first edge, then flags, halts, captures.
// - Capture end edge is falling with invert set, rising otherwise.
// - Mode field sits at control bits 7 to 4.
// - Enable clears the counter, then loads the load value on first tick, or on the start edge in modes 4 and 5.
// - Overflow sets overflow flag and interrupt when enabled.
// - Compare flag clears by writing one, or by interrupt service.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "ttem_cfg.svh"
module ttem_timer #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Prescaler tick and interrupt service acknowledges
  input  wire logic           prescale_tick,
  input  wire logic           cmp_irq_ack,
  input  wire logic           ovf_irq_ack,
  // Timer pin
  input  wire logic           timer_io_pin_i,
  output logic                timer_io_pin_o,
  output logic                timer_io_pin_oe,
  // Interrupt requests
  output logic                cmp_irq,
  output logic                ovf_irq
);
  import ttem_pkg::*;

  if (WIDTH != 24) begin : g_chk
    $error("ttem_timer supports only a 24-bit counter");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         timer_enable_bit;
    logic         overflow_irq_enable;
    logic         compare_irq_enable;
    logic [3:0]   timer_mode_field;
    logic         io_polarity_invert;
    logic         reload_on_match;
    logic         prescale_select;
    logic         compare_flag;
    logic         overflow_flag;
    ttem_word_t   load_value_reg;
    ttem_word_t   compare_value_reg;
    ttem_word_t   count_capture_reg;
    ttem_word_t   counter;
    ttem_state_e  state;
    logic         reload_pend;
    logic         pin_out;
    logic [31:0]  rdata;
  } ttem_state_s;

  ttem_state_s st;
  ttem_state_s next_st;

  ttem_edge_if pin_edges ();

  ttem_pin_sync #(
    .STAGES (`TTEM_EXT_SYNC_STAGES)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (timer_io_pin_i),
    .edge_out (pin_edges.sampler)
  );

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic       apb_wr;
  logic       apb_rd;
  logic       start_edge;
  logic       end_edge;
  logic       tick;
  logic       mode_known;
  logic [23:0] csr_view;
  logic       wr_hit;

  always_comb begin
    apb_wr     = psel & penable & pwrite;
    apb_rd     = psel & ~penable & ~pwrite;
    start_edge = st.io_polarity_invert ? pin_edges.fall : pin_edges.rise;
    end_edge   = st.io_polarity_invert ? pin_edges.rise : pin_edges.fall;
    mode_known = (st.timer_mode_field == TTEM_MODE_TOGGLE) || (st.timer_mode_field == TTEM_MODE_EVENT) ||
                 (st.timer_mode_field == TTEM_MODE_WIDTH) || (st.timer_mode_field == TTEM_MODE_PERIOD) ||
                 (st.timer_mode_field == TTEM_MODE_CAPTURE);
    // Event mode tick: external pin edge or prescaler output; others count pclk
    if (st.timer_mode_field == TTEM_MODE_EVENT) begin
      tick = st.prescale_select ? prescale_tick : start_edge;
    end else begin
      tick = 1'b1;
    end
    csr_view = '0;
    csr_view[`TTEM_BIT_EN]                            = st.timer_enable_bit;
    csr_view[`TTEM_BIT_OVF_IE]                        = st.overflow_irq_enable;
    csr_view[`TTEM_BIT_CMP_IE]                        = st.compare_irq_enable;
    csr_view[`TTEM_BIT_MODE_HI:`TTEM_BIT_MODE_LO]     = st.timer_mode_field;
    csr_view[`TTEM_BIT_INV]                           = st.io_polarity_invert;
    csr_view[`TTEM_BIT_TRM]                           = st.reload_on_match;
    csr_view[`TTEM_BIT_PSC_SEL]                       = st.prescale_select;
    csr_view[`TTEM_BIT_OVF_FLAG]                      = st.overflow_flag;
    csr_view[`TTEM_BIT_CMP_FLAG]                      = st.compare_flag;
    wr_hit = (paddr == `TTEM_CSR_OFF) || (paddr == `TTEM_LOAD_OFF) || (paddr == `TTEM_CMP_OFF) ||
             (paddr == `TTEM_CAPT_OFF) || (paddr == `TTEM_CNT_OFF);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic was_en;
    logic set_cmp;
    logic set_ovf;
    logic [24:0] inc;
    was_en  = st.timer_enable_bit;
    set_cmp = 1'b0;
    set_ovf = 1'b0;
    inc     = {1'b0, st.counter} + 25'h0000001;
    next_st = st;

    // Counter engine
    if (!st.timer_enable_bit || !mode_known) begin
      next_st.state = TTEM_ST_IDLE;
    end else begin
      case (st.state)
        TTEM_ST_IDLE: begin
          next_st.counter = `TTEM_CNT_RESET;
          next_st.pin_out = st.io_polarity_invert;
          if ((st.timer_mode_field == TTEM_MODE_WIDTH) || (st.timer_mode_field == TTEM_MODE_PERIOD)) begin
            next_st.state = TTEM_ST_WAIT;
          end else begin
            next_st.state = TTEM_ST_LOAD;
          end
        end
        TTEM_ST_LOAD: begin
          if (tick) begin
            next_st.counter = st.load_value_reg;
            next_st.state   = TTEM_ST_RUN;
          end
        end
        TTEM_ST_WAIT: begin
          if (start_edge) begin
            next_st.counter = st.load_value_reg;
            next_st.state   = TTEM_ST_RUN;
          end
        end
        TTEM_ST_RUN: begin
          case (st.timer_mode_field)
            TTEM_MODE_TOGGLE, TTEM_MODE_EVENT: begin
              if (tick) begin
                if (st.reload_pend) begin
                  next_st.counter     = st.load_value_reg;
                  next_st.reload_pend = 1'b0;
                end else begin
                  next_st.counter = inc[23:0];
                  set_ovf         = inc[24];
                  if (inc[23:0] == st.compare_value_reg) begin
                    set_cmp             = 1'b1;
                    next_st.reload_pend = st.reload_on_match;
                    if (st.timer_mode_field == TTEM_MODE_TOGGLE) begin
                      next_st.pin_out = ~st.pin_out;
                    end
                  end
                end
              end
            end
            TTEM_MODE_WIDTH: begin
              if (end_edge) begin
                next_st.count_capture_reg = st.counter;
                set_cmp                   = 1'b1;
                next_st.state             = st.reload_on_match ? TTEM_ST_WAIT : TTEM_ST_RUN;
                if (!st.reload_on_match) begin
                  next_st.counter = inc[23:0];
                  set_ovf         = inc[24];
                end
              end else begin
                next_st.counter = inc[23:0];
                set_ovf         = inc[24];
              end
            end
            TTEM_MODE_PERIOD: begin
              next_st.counter = inc[23:0];
              set_ovf         = inc[24];
              if (start_edge) begin
                next_st.count_capture_reg = st.counter;
                set_cmp                   = 1'b1;
                if (st.reload_on_match) begin
                  next_st.counter = st.load_value_reg;
                  set_ovf         = 1'b0;
                end
              end
            end
            default: begin
              // Capture: counts from enable, halts at the start edge
              if (start_edge) begin
                next_st.count_capture_reg = st.counter;
                set_cmp                   = 1'b1;
                next_st.state             = TTEM_ST_WAIT;
              end else begin
                next_st.counter = inc[23:0];
                set_ovf         = inc[24];
              end
            end
          endcase
        end
        default: begin
          next_st.state = TTEM_ST_IDLE;
        end
      endcase
    end
    // Capture halt parks in WAIT; keep it from restarting
    if ((st.timer_mode_field == TTEM_MODE_CAPTURE) && (st.state == TTEM_ST_WAIT)) begin
      next_st.state   = TTEM_ST_WAIT;
      next_st.counter = st.counter;
    end

    // Register writes
    if (apb_wr) begin
      if (paddr == `TTEM_CSR_OFF) begin
        next_st.timer_enable_bit    = pwdata[`TTEM_BIT_EN];
        next_st.overflow_irq_enable = pwdata[`TTEM_BIT_OVF_IE];
        next_st.compare_irq_enable  = pwdata[`TTEM_BIT_CMP_IE];
        next_st.timer_mode_field    = pwdata[`TTEM_BIT_MODE_HI:`TTEM_BIT_MODE_LO];
        next_st.io_polarity_invert  = pwdata[`TTEM_BIT_INV];
        next_st.reload_on_match     = pwdata[`TTEM_BIT_TRM];
        next_st.prescale_select     = pwdata[`TTEM_BIT_PSC_SEL];
        if (pwdata[`TTEM_BIT_CMP_FLAG]) begin
          next_st.compare_flag = 1'b0;
        end
        if (pwdata[`TTEM_BIT_OVF_FLAG]) begin
          next_st.overflow_flag = 1'b0;
        end
        if (!was_en && pwdata[`TTEM_BIT_EN]) begin
          next_st.state       = TTEM_ST_IDLE;
          next_st.reload_pend = 1'b0;
        end
      end else if (paddr == `TTEM_LOAD_OFF) begin
        next_st.load_value_reg = pwdata[23:0];
      end else if (paddr == `TTEM_CMP_OFF) begin
        next_st.compare_value_reg = pwdata[23:0];
      end
    end
    if (cmp_irq_ack) begin
      next_st.compare_flag = 1'b0;
    end
    if (ovf_irq_ack) begin
      next_st.overflow_flag = 1'b0;
    end
    // Hardware set wins over a same-cycle clear
    if (set_cmp) begin
      next_st.compare_flag = 1'b1;
    end
    if (set_ovf) begin
      next_st.overflow_flag = 1'b1;
    end

    // Read data captured in the setup phase
    if (apb_rd) begin
      if (paddr == `TTEM_CSR_OFF) begin
        next_st.rdata = {8'h00, csr_view};
      end else if (paddr == `TTEM_CMP_OFF) begin
        next_st.rdata = {8'h00, st.compare_value_reg};
      end else if (paddr == `TTEM_CAPT_OFF) begin
        next_st.rdata = {8'h00, st.count_capture_reg};
      end else if (paddr == `TTEM_CNT_OFF) begin
        next_st.rdata = {8'h00, st.counter};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                     <= '0;
      st.timer_mode_field    <= 4'(`TTEM_CSR_RESET >> `TTEM_BIT_MODE_LO);
      st.state               <= TTEM_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata          = st.rdata;
  assign pready          = 1'b1;
  assign pslverr         = psel & penable & ~wr_hit;
  assign timer_io_pin_o  = st.pin_out;
  assign timer_io_pin_oe = st.timer_enable_bit && (st.timer_mode_field == TTEM_MODE_TOGGLE);
  assign cmp_irq         = st.compare_flag & st.compare_irq_enable;
  assign ovf_irq         = st.overflow_flag & st.overflow_irq_enable;
endmodule

// ==== ttem_timer_asserts.sv ====
// Port-level checker for the timer channel
`timescale 1ns/10ps
`include "ttem_cfg.svh"
module ttem_timer_chk #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Ticks, acknowledges and pin
  input wire logic        prescale_tick,
  input wire logic        cmp_irq_ack,
  input wire logic        ovf_irq_ack,
  input wire logic        timer_io_pin_i,
  input wire logic        timer_io_pin_o,
  input wire logic        timer_io_pin_oe,
  // Interrupts
  input wire logic        cmp_irq,
  input wire logic        ovf_irq
);
  // ----------------------------------------
  // Shadow of the control bits
  // ----------------------------------------
  logic       en_s, oie_s, cie_s, inv_s;
  logic [3:0] mode_s;
  wire logic  csr_wr = psel && penable && pwrite && paddr == `TTEM_CSR_OFF;
  wire logic  w1c    = csr_wr && pwdata[21];
  wire logic  mapped = paddr inside {`TTEM_CSR_OFF, `TTEM_LOAD_OFF, `TTEM_CMP_OFF, `TTEM_CAPT_OFF, `TTEM_CNT_OFF};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_s, oie_s, cie_s, inv_s, mode_s} <= 8'h00;
    end else if (csr_wr) begin
      {en_s, oie_s, cie_s, inv_s, mode_s} <= {pwdata[0], pwdata[1], pwdata[2], pwdata[8], pwdata[7:4]};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OE_MODE: assert property (timer_io_pin_oe == (en_s && mode_s == 4'h2))
    else $error("pin enable does not follow toggle mode");
  AST_PIN_INIT: assert property ($rose(timer_io_pin_oe) |-> ##[0:1] timer_io_pin_o == inv_s)
    else $error("pin did not start at the invert bit");
  AST_TGL_FLAG: assert property (timer_io_pin_oe && $past(timer_io_pin_oe, 2) && $changed(timer_io_pin_o) && cie_s
    |-> ##[0:1] cmp_irq)
    else $error("toggle without compare interrupt");
  AST_CMP_IE: assert property (cmp_irq |-> cie_s)
    else $error("compare interrupt while disabled");
  AST_OVF_IE: assert property (ovf_irq |-> oie_s)
    else $error("overflow interrupt while disabled");
  AST_RD_HIGH: assert property (psel && penable && !pwrite |-> prdata[31:24] == 8'h00)
    else $error("read data above bit 23 not zero");
  AST_UNMAPPED: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not match the address map");
  AST_FLAG_CLR: assert property ((cmp_irq_ack || w1c) && mode_s inside {4'h4, 4'h5, 4'h6} |=> !cmp_irq)
    else $error("compare flag not cleared");
  AST_EDGE_LAT: assert property (mode_s == 4'h6 && en_s && cie_s && !cmp_irq
    && (inv_s ? $fell(timer_io_pin_i) : $rose(timer_io_pin_i))
    |-> ##1 !cmp_irq ##[1:4] cmp_irq)
    else $error("capture edge not flagged in time");
endmodule

bind ttem_timer ttem_timer_chk #(.WIDTH(WIDTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prescale_tick(prescale_tick),
  .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack), .timer_io_pin_i(timer_io_pin_i),
  .timer_io_pin_o(timer_io_pin_o), .timer_io_pin_oe(timer_io_pin_oe), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq));
